// >>> logic/dcdcc_consts.vh
`ifndef DCDCC_CONSTS_VH
`define DCDCC_CONSTS_VH

// Register address in special function register space
`define DCDCC_CFG_ADDR      8'h96
`define DCDCC_CFG_RESET     8'h00
// Writable bits; the top bit is held at zero
`define DCDCC_CFG_WMASK     8'h7f

// Field positions
`define DCDCC_RESERVED_BIT  7
`define DCDCC_DIV_HI        6
`define DCDCC_DIV_LO        5
`define DCDCC_SARINV_BIT    4
`define DCDCC_SYSINV_BIT    3
`define DCDCC_ILIM_BIT      2
`define DCDCC_SLEEP_BIT     1
`define DCDCC_SRC_BIT       0

// Divider codes
`define DCDCC_DIV_BY1       2'h0
`define DCDCC_DIV_BY2       2'h1
`define DCDCC_DIV_BY4       2'h2
`define DCDCC_DIV_BY8       2'h3

`endif

// >>> logic/dcdcc_clock_config.v
`timescale 1ns/100ps
`include "dcdcc_consts.vh"

// Behaviour
// R1: Bit 7 of the configuration register reads as zero and software writes zero to it.
// R2: With the system clock selected the divider codes 00..11 divide it by 1, 2, 4 and 8.
// R3: The divider field has no effect while the local oscillator is the source.
// R4: With sync enabled the SAR clock is inverted when its inversion bit is 0, not when 1.
// R5: The SAR inversion bit is ignored while sync is disabled.
// R6: The system clock invert bit inverts the system clock ahead of the divider when 1.
// R7: The current limit bit picks the lower peak threshold at 0 and the higher at 1.
// R8: Enabled and asleep, the sleep bit ties the output node to battery at 0, floats it at 1.
// R9: The source bit selects the local oscillator at 0 and the system clock path at 1.
// R10: With sync enabled, tracking falls in the quiet interval and the SAR clock follows it.
// R11: Setting changes switch the converter clock without runt pulses or glitches; at divide by 1 on the system clock an invert-only change never applies.
module dcdcc_clock_config (
  input  wire       ref_clk,
  input  wire       arst_n,
  input  wire [7:0] sfr_addr,
  input  wire [7:0] sfr_wdata,
  input  wire       sfr_wr,
  input  wire       sfr_rd,
  output reg  [7:0] sfr_rdata,
  input  wire       sys_clk_in,
  input  wire       local_osc_in,
  input  wire       sync_enable,
  input  wire       converter_enable,
  input  wire       sleep_mode,
  output wire       converter_clk,
  output wire       sar_clk,
  output wire       sar_track_en,
  output wire       peak_limit_high,
  output wire       node_tied_to_battery,
  output wire       node_floating
);

  reg  [7:0] converter_config_reg;
  reg        act_src_reg;
  reg  [1:0] act_div_reg;
  reg        act_inv_reg;
  reg        sys_prev_reg;
  reg  [2:0] div_cnt_reg;
  reg        conv_clk_reg;
  reg        sar_clk_reg;
  reg        track_reg;

  reg  [7:0] converter_config_next;
  reg  [7:0] sfr_rdata_next;
  reg        act_src_next;
  reg  [1:0] act_div_next;
  reg        act_inv_next;
  reg  [2:0] div_cnt_next;
  reg        conv_clk_next;
  reg        sar_clk_next;
  reg        track_next;

  wire       cfg_src;
  wire [1:0] cfg_div;
  wire       cfg_inv;
  wire       sys_act;
  wire       clk_cur;
  wire       clk_new;
  wire       settings_differ;
  wire       switch_ok;
  wire       wr_hit;
  wire       rd_hit;
  wire       sys_rise;
  wire       src_differ;
  wire       div_differ;
  wire       inv_differ;
  wire       asleep;

  // Address decode for the configuration register
  function addr_hit;
    input [7:0] addr;
    begin
      addr_hit = (addr == `DCDCC_CFG_ADDR);
    end
  endfunction

  // Converter clock from a given set of settings
  function pick_clk;
    input       src;
    input [1:0] div;
    input       sys;
    input       lo;
    input [2:0] cnt;
    begin
      if (!src) begin
        pick_clk = lo; // [R9] [R3]
      end else begin
        case (div) // [R2]
          `DCDCC_DIV_BY1: pick_clk = sys;
          `DCDCC_DIV_BY2: pick_clk = cnt[0];
          `DCDCC_DIV_BY4: pick_clk = cnt[1];
          `DCDCC_DIV_BY8: pick_clk = cnt[2];
          default:        pick_clk = sys;
        endcase
      end
    end
  endfunction

  assign cfg_src = converter_config_reg[`DCDCC_SRC_BIT];
  assign cfg_div = converter_config_reg[`DCDCC_DIV_HI:`DCDCC_DIV_LO];
  assign cfg_inv = converter_config_reg[`DCDCC_SYSINV_BIT];

  assign wr_hit   = sfr_wr && addr_hit(sfr_addr);
  assign rd_hit   = sfr_rd && addr_hit(sfr_addr);
  assign sys_rise = sys_act && !sys_prev_reg;

  // Inverted ahead of the divider
  assign sys_act = sys_clk_in ^ act_inv_reg; // [R6]

  assign clk_cur = pick_clk(act_src_reg, act_div_reg, sys_act, local_osc_in, div_cnt_reg);
  assign clk_new = pick_clk(cfg_src, cfg_div, sys_clk_in ^ cfg_inv, local_osc_in,
                            div_cnt_reg);

  assign src_differ      = act_src_reg != cfg_src;
  assign div_differ      = act_div_reg != cfg_div;
  assign inv_differ      = act_inv_reg != cfg_inv;
  assign settings_differ = src_differ || div_differ || inv_differ;
  // Swap only while old and new clocks are both low
  assign switch_ok = settings_differ && !conv_clk_reg && !clk_cur && !clk_new; // [R11]

  // Configuration register and read data
  always @* begin
    converter_config_next = converter_config_reg;
    sfr_rdata_next        = sfr_rdata;
    if (wr_hit) begin
      converter_config_next = sfr_wdata & `DCDCC_CFG_WMASK; // [R1]
    end
    if (rd_hit) begin
      sfr_rdata_next = converter_config_reg & `DCDCC_CFG_WMASK; // [R1]
    end else if (sfr_rd) begin
      sfr_rdata_next = 8'h00;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_config_reg <= `DCDCC_CFG_RESET;
      sfr_rdata            <= 8'h00;
    end else begin
      converter_config_reg <= converter_config_next;
      sfr_rdata            <= sfr_rdata_next;
    end
  end

  // Divider counts rising edges of the possibly inverted system clock
  always @* begin
    div_cnt_next = div_cnt_reg;
    if (sys_rise) begin
      div_cnt_next = div_cnt_reg + 3'h1; // [R2]
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_prev_reg <= 1'b0;
      div_cnt_reg  <= 3'h0;
    end else begin
      sys_prev_reg <= sys_act;
      div_cnt_reg  <= div_cnt_next;
    end
  end

  // Active settings swap only at a common low point
  always @* begin
    act_src_next  = act_src_reg;
    act_div_next  = act_div_reg;
    act_inv_next  = act_inv_reg;
    conv_clk_next = clk_cur;
    if (switch_ok) begin
      act_src_next  = cfg_src; // [R11]
      act_div_next  = cfg_div;
      act_inv_next  = cfg_inv;
      conv_clk_next = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      act_src_reg  <= 1'b0;
      act_div_reg  <= `DCDCC_DIV_BY1;
      act_inv_reg  <= 1'b0;
      conv_clk_reg <= 1'b0;
    end else begin
      act_src_reg  <= act_src_next;
      act_div_reg  <= act_div_next;
      act_inv_reg  <= act_inv_next;
      conv_clk_reg <= conv_clk_next;
    end
  end

  // SAR clock and tracking window
  always @* begin
    sar_clk_next = 1'b0; // [R5]
    track_next   = 1'b0;
    if (sync_enable) begin
      sar_clk_next = conv_clk_reg ^ ~converter_config_reg[`DCDCC_SARINV_BIT]; // [R4]
      track_next   = ~conv_clk_reg; // [R10]
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_clk_reg <= 1'b0;
      track_reg   <= 1'b0;
    end else begin
      sar_clk_reg <= sar_clk_next;
      track_reg   <= track_next;
    end
  end

  // Outputs
  assign converter_clk        = conv_clk_reg;
  assign sar_clk              = sar_clk_reg;
  assign sar_track_en         = track_reg;
  assign peak_limit_high      = converter_config_reg[`DCDCC_ILIM_BIT]; // [R7]
  assign asleep               = converter_enable && sleep_mode;
  assign node_tied_to_battery = asleep && !converter_config_reg[`DCDCC_SLEEP_BIT]; // [R8]
  assign node_floating        = asleep && converter_config_reg[`DCDCC_SLEEP_BIT]; // [R8]

endmodule

// >>> sim/dcdcc_checker.sv
`timescale 1ns/100ps
module dcdcc_checker (
  input       ref_clk,
  input       arst_n,
  input [7:0] sfr_addr,
  input [7:0] sfr_wdata,
  input       sfr_wr,
  input       sfr_rd,
  input [7:0] sfr_rdata,
  input       sync_enable,
  input       converter_enable,
  input       sleep_mode,
  input       converter_clk,
  input       sar_clk,
  input       sar_track_en,
  input       peak_limit_high,
  input       node_tied_to_battery,
  input       node_floating
);
  logic [7:0] cfg_reg;
  wire        asleep = converter_enable && sleep_mode;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence synced_s; sync_enable [*3] ##0 $stable(cfg_reg); endsequence
  always_ff @(posedge ref_clk or negedge arst_n)
    if (!arst_n) cfg_reg <= 8'h00;
    else if (sfr_wr && sfr_addr == 8'h96) cfg_reg <= sfr_wdata & 8'h7f;
  AST_READ: assert property (sfr_rd && sfr_addr == 8'h96 |=> sfr_rdata == $past(cfg_reg))
    else $error("config read");
  AST_UNMAP: assert property (sfr_rd && sfr_addr != 8'h96 |=> sfr_rdata == 8'h00)
    else $error("unmapped read");
  AST_LIMIT: assert property (peak_limit_high == cfg_reg[2])
    else $error("limit level");
  AST_TIE: assert property (node_tied_to_battery == (asleep && !cfg_reg[1]))
    else $error("node tie");
  AST_FLOAT: assert property (node_floating == (asleep && cfg_reg[1]))
    else $error("node float");
  AST_SAR_OFF: assert property ((!sync_enable) [*3] |-> !sar_clk && !sar_track_en)
    else $error("sar while unsynced");
  AST_SAR: assert property (synced_s |-> sar_clk == ($past(converter_clk) ^ !cfg_reg[4]))
    else $error("sar polarity");
  AST_TRACK: assert property (sync_enable [*3] |-> sar_track_en == !$past(converter_clk))
    else $error("track window");
endmodule
bind dcdcc_clock_config dcdcc_checker chk_i (.*);

// >>> sim/dcdcc_tb.sv
`timescale 1ns/100ps
module tb;
  logic       ref_clk = 1'h0, arst_n = 1'h0, sfr_wr = 1'h0, sfr_rd = 1'h0, sys_clk_in = 1'h0;
  logic       local_osc_in = 1'h0, sync_enable = 1'h1, converter_enable = 1'h0, sleep_mode = 1'h0;
  logic       converter_clk, sar_clk, sar_track_en, peak_limit_high;
  logic       node_tied_to_battery, node_floating;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic [2:0] ph = 3'h0;
  int         errors = 0, compares = 0;
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ph <= ph + 3'h1;
    sys_clk_in <= ph[1];
    local_osc_in <= ph[2];
  end
  dcdcc_clock_config uut (
    .ref_clk              (ref_clk),
    .arst_n               (arst_n),
    .sfr_addr             (sfr_addr),
    .sfr_wdata            (sfr_wdata),
    .sfr_wr               (sfr_wr),
    .sfr_rd               (sfr_rd),
    .sfr_rdata            (sfr_rdata),
    .sys_clk_in           (sys_clk_in),
    .local_osc_in         (local_osc_in),
    .sync_enable          (sync_enable),
    .converter_enable     (converter_enable),
    .sleep_mode           (sleep_mode),
    .converter_clk        (converter_clk),
    .sar_clk              (sar_clk),
    .sar_track_en         (sar_track_en),
    .peak_limit_high      (peak_limit_high),
    .node_tied_to_battery (node_tied_to_battery),
    .node_floating        (node_floating)
  );
  task close_out;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rst;
    @(posedge ref_clk);
    arst_n <= 1'h0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'h1;
    @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] d);
    sfr_addr <= 8'h96;
    sfr_wdata <= d;
    sfr_wr <= 1'h1;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, e);
    sfr_addr <= a;
    sfr_rd <= 1'h1;
    @(posedge ref_clk);
    sfr_rd <= 1'h0;
    @(negedge ref_clk);
    chk(sfr_rdata, e);
    @(posedge ref_clk);
  endtask
  task rate(input logic [7:0] c, input int e);
    int   n;
    int   h;
    int   runt;
    int   i;
    logic l;
    rst;
    wr(c);
    n = 0;
    h = 2;
    runt = 0;
    l = 1'h0;
    for (i = 0; i < 544; i++) begin
      @(negedge ref_clk);
      if (converter_clk) begin
        h++;
        if (!l && i >= 32) n++;
      end else begin
        if (l && h < 2) runt++;
        h = 0;
      end
      l = converter_clk;
    end
    chk(8'(n), 8'(e));
    chk(8'(runt), 8'h00);
  endtask
  task phase(input logic [7:0] c);
    logic s;
    int   m;
    rst;
    wr(c);
    repeat (32) @(posedge ref_clk);
    @(negedge ref_clk);
    s = sys_clk_in;
    m = 0;
    repeat (16) begin
      @(negedge ref_clk);
      m += (converter_clk !== (s ^ c[3]));
      s = sys_clk_in;
    end
    chk(8'(m), 8'h00);
  endtask
  initial begin
    #200000;
    errors++;
    close_out;
  end
  initial begin
    rst;
    rd(8'h96, 8'h00);
    wr(8'h7f);
    rd(8'h96, 8'h7f);
    rd(8'h95, 8'h00);
    chk(8'(peak_limit_high), 8'h01);
    converter_enable <= 1'h1;
    sleep_mode <= 1'h1;
    sync_enable <= 1'h0;
    @(negedge ref_clk);
    chk(8'({node_tied_to_battery, node_floating}), 8'h01);
    @(posedge ref_clk);
    wr(8'h00);
    repeat (4) @(negedge ref_clk);
    chk(8'({node_tied_to_battery, node_floating}), 8'h02);
    chk(8'({sar_clk, sar_track_en}), 8'h00);
    @(posedge ref_clk);
    sync_enable <= 1'h1;
    rate(8'h01, 128);
    rate(8'h21, 64);
    rate(8'h49, 32);
    rate(8'h79, 16);
    rate(8'h60, 64);
    phase(8'h01);
    phase(8'h09);
    close_out;
  end
endmodule
